// File: rtl/pdc_regs_pkg.sv
/*
  Constants, types and helpers shared by the peripheral DMA channel
  register block and its transfer enable controller.
  Assumes a single 10 MHz clock domain and a plain strobe register port.
*/
package periph_dma_regs_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_RX_CUR_ADDR = 12'h100;
  localparam logic [11:0] OFS_RX_CUR_COUNT = 12'h104;
  localparam logic [11:0] OFS_TX_CUR_ADDR = 12'h108;
  localparam logic [11:0] OFS_TX_CUR_COUNT = 12'h10C;
  localparam logic [11:0] OFS_RX_NEXT_ADDR = 12'h110;
  localparam logic [11:0] OFS_RX_NEXT_COUNT = 12'h114;
  localparam logic [11:0] OFS_TX_NEXT_ADDR = 12'h118;
  localparam logic [11:0] OFS_TX_NEXT_COUNT = 12'h11C;
  localparam logic [11:0] OFS_CONTROL = 12'h120;
  localparam logic [11:0] OFS_STATUS = 12'h124;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int CTRL_RX_ON_BIT = 0;
  localparam int CTRL_RX_OFF_BIT = 1;
  localparam int CTRL_TX_ON_BIT = 8;
  localparam int CTRL_TX_OFF_BIT = 9;
  localparam int STAT_RX_BIT = 0;
  localparam int STAT_TX_BIT = 8;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam int CH_RX = 0;
  localparam int CH_TX = 1;
  localparam int NUM_CH = 2;

  // ------------------------------------------------------------
  // Transfer unit and pointer step
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'b00,
    SIZE_HALF = 2'b01,
    SIZE_WORD = 2'b10
  } xfer_size_e;
  localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] STEP_HALF = 32'h0000_0002;
  localparam logic [31:0] STEP_WORD = 32'h0000_0004;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic [31:0] cur_addr;
    logic [15:0] cur_count;
    logic [31:0] next_addr;
    logic [15:0] next_count;
    logic busy;
    logic end_flag;
    logic buf_flag;
  } chan_s;

  typedef struct packed {
    chan_s [NUM_CH-1:0] chan;
    logic [31:0] rdata;
  } top_state_s;

  typedef struct packed {
    logic rx_on;
    logic tx_on;
  } enable_s;

  function automatic logic [31:0] step_of(input xfer_size_e size);
    case (size)
      SIZE_BYTE: step_of = STEP_BYTE;
      SIZE_HALF: step_of = STEP_HALF;
      default: step_of = STEP_WORD;
    endcase
  endfunction

endpackage

// File: rtl/transfer_enable_ctrl.sv
/*
  Transfer enable controller: turns control register writes into the
  receive and transmit request enable state.
  Assumes the write strobe and data come from the same clock domain.
*/
`timescale 1ns/1ps
module transfer_enable_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ctrl_wr_i,
  input wire logic [31:0] wdata_i,
  input wire logic half_duplex_i,
  output logic rx_on_o,
  output logic tx_on_o
);
  import periph_dma_regs_pkg::*;

  enable_s st;
  enable_s next_st;
  logic rx_on_req;
  logic rx_off_req;
  logic tx_on_req;
  logic tx_off_req;

  assign rx_on_req = wdata_i[CTRL_RX_ON_BIT];
  assign rx_off_req = wdata_i[CTRL_RX_OFF_BIT];
  assign tx_on_req = wdata_i[CTRL_TX_ON_BIT];
  assign tx_off_req = wdata_i[CTRL_TX_OFF_BIT];

  always_comb begin
    next_st = st;
    if (ctrl_wr_i) begin
      if (half_duplex_i) begin
        if (rx_off_req || tx_off_req) begin
          next_st.rx_on = 1'b0;
          next_st.tx_on = 1'b0;
        end else if (rx_on_req) begin
          next_st.rx_on = 1'b1;
          next_st.tx_on = 1'b0;
        end else if (tx_on_req) begin
          next_st.tx_on = 1'b1;
          next_st.rx_on = 1'b0;
        end
      end else begin
        if (rx_off_req) begin
          next_st.rx_on = 1'b0;
        end else if (rx_on_req) begin
          next_st.rx_on = 1'b1;
        end
        if (tx_off_req) begin
          next_st.tx_on = 1'b0;
        end else if (tx_on_req) begin
          next_st.tx_on = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rx_on_o = st.rx_on;
  assign tx_on_o = st.tx_on;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_RX_ON: assert property (
    ctrl_wr_i && !half_duplex_i && rx_on_req && !rx_off_req |=> rx_on_o)
    else $error("receive enable write ignored");
  AST_RX_OFF_WINS: assert property (
    ctrl_wr_i && rx_off_req |=> !rx_on_o)
    else $error("receive disable did not win");
  AST_TX_ON: assert property (
    ctrl_wr_i && !half_duplex_i && tx_on_req && !tx_off_req
    |=> tx_on_o && (rx_on_o == (!$past(rx_off_req) &&
    ($past(rx_on_o) || $past(rx_on_req)))))
    else $error("transmit enable write ignored");
  AST_TX_OFF: assert property (
    ctrl_wr_i && tx_off_req |=> !tx_on_o)
    else $error("transmit disable ignored");
  AST_HD_RX_KILLS_TX: assert property (
    ctrl_wr_i && half_duplex_i && rx_on_req && !rx_off_req && !tx_off_req
    |=> rx_on_o && !tx_on_o)
    else $error("half duplex receive enable left transmit on");
  AST_HD_TX_BLOCKED: assert property (
    ctrl_wr_i && half_duplex_i && tx_on_req && rx_on_req |=> !tx_on_o)
    else $error("half duplex transmit enabled beside receive");
  AST_HD_OFF_BOTH: assert property (
    ctrl_wr_i && half_duplex_i && (rx_off_req || tx_off_req)
    |=> !rx_on_o && !tx_on_o)
    else $error("half duplex disable left a direction on");
  AST_HOLD_NO_WRITE: assert property (
    !ctrl_wr_i |=> $stable(rx_on_o) && $stable(tx_on_o))
    else $error("enable state changed without write");

endmodule // transfer_enable_ctrl

// File: rtl/peripheral_dma_channel_regs.sv
/*
  Peripheral DMA channel pair: register file, transfer enables and the
  pointer and counter engines of the receive and transmit channels.
  Assumes a single clock, a strobe register port with read data one
  cycle later, and a peripheral and bus matrix on the same clock that
  answer each request with a one-cycle acknowledge.
*/
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module peripheral_dma_channel_regs (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire periph_dma_regs_pkg::reg_req_s BUS_I,
  output logic [31:0] RDATA_O,
  input wire logic HALF_DUPLEX_I,
  input wire periph_dma_regs_pkg::xfer_size_e RX_SIZE_I,
  input wire periph_dma_regs_pkg::xfer_size_e TX_SIZE_I,
  input wire logic RX_READY_I,
  input wire logic TX_READY_I,
  input wire logic RX_ACK_I,
  input wire logic TX_ACK_I,
  output logic RX_REQ_O,
  output logic [31:0] RX_ADDR_O,
  output logic TX_REQ_O,
  output logic [31:0] TX_ADDR_O,
  output logic RX_END_O,
  output logic RX_FULL_O,
  output logic TX_END_O,
  output logic TX_EMPTY_O,
  output logic RX_ON_O,
  output logic TX_ON_O
);
  import periph_dma_regs_pkg::*;

  top_state_s st;
  top_state_s next_st;
  logic rx_on;
  logic tx_on;
  logic ctrl_wr;
  logic [NUM_CH-1:0] wr_ca;
  logic [NUM_CH-1:0] wr_cc;
  logic [NUM_CH-1:0] wr_na;
  logic [NUM_CH-1:0] wr_nc;
  logic [NUM_CH-1:0] clr;
  logic [NUM_CH-1:0] run_en;
  logic [NUM_CH-1:0] ready;
  logic [NUM_CH-1:0] ack;
  logic [31:0] step [NUM_CH];
  logic wdata_count_nz;

  // ------------------------------------------------------------
  // Transfer enables
  // ------------------------------------------------------------
  assign ctrl_wr = BUS_I.wr && (BUS_I.addr == OFS_CONTROL);

  transfer_enable_ctrl u_enable (
    .clk_i(MCLK_I),
    .rst_i(RESET_I),
    .ctrl_wr_i(ctrl_wr),
    .wdata_i(BUS_I.wdata),
    .half_duplex_i(HALF_DUPLEX_I),
    .rx_on_o(rx_on),
    .tx_on_o(tx_on)
  );

  assign wdata_count_nz = (BUS_I.wdata[15:0] != COUNT_RESET);

  // ------------------------------------------------------------
  // Per-channel write decode and handshake routing
  // ------------------------------------------------------------
  // In half duplex the transmit engine is the one shared channel and
  // the receive offsets alias onto it; the receive engine stays idle.
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
    localparam logic [11:0] OWN_CA =
      (c == CH_RX) ? OFS_RX_CUR_ADDR : OFS_TX_CUR_ADDR;
    localparam logic [11:0] OWN_CC =
      (c == CH_RX) ? OFS_RX_CUR_COUNT : OFS_TX_CUR_COUNT;
    localparam logic [11:0] OWN_NA =
      (c == CH_RX) ? OFS_RX_NEXT_ADDR : OFS_TX_NEXT_ADDR;
    localparam logic [11:0] OWN_NC =
      (c == CH_RX) ? OFS_RX_NEXT_COUNT : OFS_TX_NEXT_COUNT;
    logic own_ok;
    logic alias_ok;

    assign own_ok = (c == CH_RX) ? !HALF_DUPLEX_I : 1'b1;
    assign alias_ok = (c == CH_TX) ? HALF_DUPLEX_I : 1'b0;

    assign wr_ca[c] = BUS_I.wr && ((own_ok && BUS_I.addr == OWN_CA) ||
      (alias_ok && BUS_I.addr == OFS_RX_CUR_ADDR));
    assign wr_cc[c] = BUS_I.wr && ((own_ok && BUS_I.addr == OWN_CC) ||
      (alias_ok && BUS_I.addr == OFS_RX_CUR_COUNT));
    assign wr_na[c] = BUS_I.wr && ((own_ok && BUS_I.addr == OWN_NA) ||
      (alias_ok && BUS_I.addr == OFS_RX_NEXT_ADDR));
    assign wr_nc[c] = BUS_I.wr && ((own_ok && BUS_I.addr == OWN_NC) ||
      (alias_ok && BUS_I.addr == OFS_RX_NEXT_COUNT));

    // Nonzero count write clears end flags
    assign clr[c] = (wr_cc[c] || wr_nc[c]) && wdata_count_nz;

    if (c == CH_RX) begin : g_rx
      assign run_en[c] = rx_on && !HALF_DUPLEX_I;
      assign ready[c] = RX_READY_I;
      assign ack[c] = RX_ACK_I;
      assign step[c] = step_of(RX_SIZE_I);
    end else begin : g_tx
      assign run_en[c] = tx_on || (HALF_DUPLEX_I && rx_on);
      assign ready[c] = (HALF_DUPLEX_I && rx_on) ? RX_READY_I : TX_READY_I;
      assign ack[c] = TX_ACK_I;
      assign step[c] = step_of(TX_SIZE_I);
    end

    // Per-channel engine checks
    AST_REQ_NEEDS_COUNT: assert property (
      @(posedge MCLK_I) disable iff (RESET_I)
      $rose(st.chan[c].busy)
      |-> $past(st.chan[c].cur_count) != COUNT_RESET && $past(run_en[c]))
      else $error("request issued with zero count or disabled");
    AST_ADDR_STEP: assert property (
      @(posedge MCLK_I) disable iff (RESET_I)
      st.chan[c].busy && ack[c] && !wr_ca[c] &&
      st.chan[c].cur_count > 16'h0001
      |=> st.chan[c].cur_addr == $past(st.chan[c].cur_addr) + $past(step[c]))
      else $error("pointer did not advance by transfer size");
    AST_RELOAD: assert property (
      @(posedge MCLK_I) disable iff (RESET_I)
      st.chan[c].busy && ack[c] && st.chan[c].cur_count == 16'h0001 &&
      st.chan[c].next_count != COUNT_RESET &&
      !(wr_ca[c] || wr_cc[c] || wr_na[c] || wr_nc[c])
      |=> st.chan[c].cur_count == $past(st.chan[c].next_count) &&
      st.chan[c].cur_addr == $past(st.chan[c].next_addr) &&
      st.chan[c].next_count == COUNT_RESET &&
      st.chan[c].next_addr == ADDR_RESET && st.chan[c].end_flag)
      else $error("next buffer not taken over at zero count");
    AST_STOP: assert property (
      @(posedge MCLK_I) disable iff (RESET_I)
      st.chan[c].busy && ack[c] && st.chan[c].cur_count == 16'h0001 &&
      st.chan[c].next_count == COUNT_RESET && !wr_cc[c] && !wr_nc[c]
      |=> st.chan[c].buf_flag && st.chan[c].end_flag &&
      st.chan[c].cur_count == COUNT_RESET ##1 !st.chan[c].busy)
      else $error("channel did not stop at last buffer end");
    AST_FLAG_CLEAR: assert property (
      @(posedge MCLK_I) disable iff (RESET_I)
      clr[c] && !(st.chan[c].busy && ack[c])
      |=> !st.chan[c].end_flag && !st.chan[c].buf_flag)
      else $error("end flags not cleared by count write");
    AST_NEXT_COUNT_WRITE: assert property (
      @(posedge MCLK_I) disable iff (RESET_I)
      wr_nc[c] |=> st.chan[c].next_count == $past(BUS_I.wdata[15:0]))
      else $error("next counter write lost");

    // Handshake and sticky flag checks
    AST_REQ_HOLD: assert property (
      @(posedge MCLK_I) disable iff (RESET_I)
      st.chan[c].busy && !ack[c] |=> st.chan[c].busy)
      else $error("request withdrawn before acknowledge");
    AST_REQ_DROP: assert property (
      @(posedge MCLK_I) disable iff (RESET_I)
      st.chan[c].busy && ack[c] |=> !st.chan[c].busy)
      else $error("request held after acknowledge");
    AST_ADDR_HOLD: assert property (
      @(posedge MCLK_I) disable iff (RESET_I)
      st.chan[c].busy && !ack[c] && !wr_ca[c]
      |=> $stable(st.chan[c].cur_addr))
      else $error("pointer moved while request waits");
    AST_END_STICKY: assert property (
      @(posedge MCLK_I) disable iff (RESET_I)
      st.chan[c].end_flag && !clr[c] |=> st.chan[c].end_flag)
      else $error("end flag dropped without count write");
    AST_BUF_STICKY: assert property (
      @(posedge MCLK_I) disable iff (RESET_I)
      st.chan[c].buf_flag && !clr[c] |=> st.chan[c].buf_flag)
      else $error("buffer flag dropped without count write");
  end

  // ------------------------------------------------------------
  // State update
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rdata = RDATA_RESET;

    // Register read, data stands in the following cycle only
    if (BUS_I.rd) begin
      unique case (BUS_I.addr)
        OFS_RX_CUR_ADDR: begin
          next_st.rdata = HALF_DUPLEX_I ? st.chan[CH_TX].cur_addr :
            st.chan[CH_RX].cur_addr;
        end
        OFS_RX_CUR_COUNT: begin
          next_st.rdata = {16'h0000, HALF_DUPLEX_I ?
            st.chan[CH_TX].cur_count : st.chan[CH_RX].cur_count};
        end
        OFS_TX_CUR_ADDR: begin
          next_st.rdata = st.chan[CH_TX].cur_addr;
        end
        OFS_TX_CUR_COUNT: begin
          next_st.rdata = {16'h0000, st.chan[CH_TX].cur_count};
        end
        OFS_RX_NEXT_ADDR: begin
          next_st.rdata = HALF_DUPLEX_I ? st.chan[CH_TX].next_addr :
            st.chan[CH_RX].next_addr;
        end
        OFS_RX_NEXT_COUNT: begin
          next_st.rdata = {16'h0000, HALF_DUPLEX_I ?
            st.chan[CH_TX].next_count : st.chan[CH_RX].next_count};
        end
        OFS_TX_NEXT_ADDR: begin
          next_st.rdata = st.chan[CH_TX].next_addr;
        end
        OFS_TX_NEXT_COUNT: begin
          next_st.rdata = {16'h0000, st.chan[CH_TX].next_count};
        end
        OFS_STATUS: begin
          next_st.rdata[STAT_RX_BIT] = rx_on;
          next_st.rdata[STAT_TX_BIT] = tx_on;
        end
        default: begin
          next_st.rdata = RDATA_RESET;
        end
      endcase
    end

    for (int c = 0; c < NUM_CH; c++) begin
      // Clear first so a hardware set in the same cycle wins
      if (clr[c]) begin
        next_st.chan[c].end_flag = 1'b0;
        next_st.chan[c].buf_flag = 1'b0;
      end

      if (st.chan[c].busy) begin
        if (ack[c]) begin
          next_st.chan[c].busy = 1'b0;
          next_st.chan[c].cur_addr = st.chan[c].cur_addr + step[c];
          if (st.chan[c].cur_count != COUNT_RESET) begin
            next_st.chan[c].cur_count = st.chan[c].cur_count - 16'h0001;
            if (st.chan[c].cur_count == 16'h0001) begin
              next_st.chan[c].end_flag = 1'b1;
              if (st.chan[c].next_count != COUNT_RESET) begin
                next_st.chan[c].cur_addr = st.chan[c].next_addr;
                next_st.chan[c].cur_count = st.chan[c].next_count;
                next_st.chan[c].next_addr = ADDR_RESET;
                next_st.chan[c].next_count = COUNT_RESET;
              end else begin
                next_st.chan[c].buf_flag = 1'b1;
              end
            end
          end
        end
      end else if (run_en[c] && ready[c] &&
                   st.chan[c].cur_count != COUNT_RESET) begin
        next_st.chan[c].busy = 1'b1;
      end

      // Software writes override the engine's own update
      if (wr_ca[c]) begin
        next_st.chan[c].cur_addr = BUS_I.wdata;
      end
      if (wr_cc[c]) begin
        next_st.chan[c].cur_count = BUS_I.wdata[15:0];
      end
      if (wr_na[c]) begin
        next_st.chan[c].next_addr = BUS_I.wdata;
      end
      if (wr_nc[c]) begin
        next_st.chan[c].next_count = BUS_I.wdata[15:0];
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign RDATA_O = st.rdata;
  assign RX_REQ_O = st.chan[CH_RX].busy;
  assign RX_ADDR_O = st.chan[CH_RX].cur_addr;
  assign TX_REQ_O = st.chan[CH_TX].busy;
  assign TX_ADDR_O = st.chan[CH_TX].cur_addr;
  assign RX_END_O = st.chan[CH_RX].end_flag;
  assign RX_FULL_O = st.chan[CH_RX].buf_flag;
  assign TX_END_O = st.chan[CH_TX].end_flag;
  assign TX_EMPTY_O = st.chan[CH_TX].buf_flag;
  assign RX_ON_O = rx_on;
  assign TX_ON_O = tx_on;

  // ------------------------------------------------------------
  // Register checks
  // ------------------------------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  AST_HD_SHARED_ADDR: assert property (
    HALF_DUPLEX_I && BUS_I.rd && BUS_I.addr == OFS_RX_CUR_ADDR
    |=> RDATA_O == $past(st.chan[CH_TX].cur_addr))
    else $error("half duplex current pointer not shared");
  AST_HD_SHARED_COUNT: assert property (
    HALF_DUPLEX_I && BUS_I.rd && BUS_I.addr == OFS_RX_CUR_COUNT
    |=> RDATA_O[15:0] == $past(st.chan[CH_TX].cur_count))
    else $error("half duplex current counter not shared");
  AST_HD_SHARED_NEXT: assert property (
    HALF_DUPLEX_I && BUS_I.wr && BUS_I.addr == OFS_RX_NEXT_COUNT
    |=> st.chan[CH_TX].next_count == $past(BUS_I.wdata[15:0]))
    else $error("half duplex next counter not shared");
  AST_RX_NEXT_ADDR: assert property (
    !HALF_DUPLEX_I && BUS_I.wr && BUS_I.addr == OFS_RX_NEXT_ADDR
    |=> st.chan[CH_RX].next_addr == $past(BUS_I.wdata))
    else $error("receive next pointer write lost");
  AST_TX_NEXT_ADDR: assert property (
    BUS_I.wr && BUS_I.addr == OFS_TX_NEXT_ADDR
    |=> st.chan[CH_TX].next_addr == $past(BUS_I.wdata))
    else $error("transmit next pointer write lost");
  AST_RX_NEXT_COUNT: assert property (
    !HALF_DUPLEX_I && BUS_I.wr && BUS_I.addr == OFS_RX_NEXT_COUNT
    ##1 !BUS_I.wr && !(RX_REQ_O && RX_ACK_I)
    ##1 BUS_I.rd && BUS_I.addr == OFS_RX_NEXT_COUNT && !HALF_DUPLEX_I
    |=> RDATA_O == {16'h0000, $past(BUS_I.wdata[15:0], 3)})
    else $error("receive next counter readback wrong");
  AST_STATUS_READ: assert property (
    BUS_I.rd && BUS_I.addr == OFS_STATUS
    |=> RDATA_O == {23'h000000, $past(TX_ON_O), 7'h00, $past(RX_ON_O)})
    else $error("status register mismatch");
  AST_COUNT_UPPER_ZERO: assert property (
    BUS_I.rd && (BUS_I.addr == OFS_TX_CUR_COUNT ||
    BUS_I.addr == OFS_CONTROL) |=> RDATA_O[31:16] == 16'h0000)
    else $error("unused bits read nonzero");
  AST_READ_ONE_CYCLE: assert property (
    !BUS_I.rd |=> RDATA_O == RDATA_RESET)
    else $error("read data held beyond answer cycle");
  AST_CONTROL_READS_ZERO: assert property (
    BUS_I.rd && BUS_I.addr == OFS_CONTROL |=> RDATA_O == RDATA_RESET)
    else $error("control register read nonzero");
  AST_HD_RX_IDLE: assert property (
    $rose(RX_REQ_O) |-> !$past(HALF_DUPLEX_I))
    else $error("receive engine requested in half duplex");

endmodule // peripheral_dma_channel_regs

// File: testbench/serial_side_model.sv
/*
  Far side of one channel: peripheral ready and bus matrix acknowledge.
  Assumes the request is registered on the same clock.
*/
`timescale 1ns/1ps
module serial_side_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic req_i,
  output logic ready_o,
  output logic ack_o
);
  logic [1:0] wait_cnt;
  logic toggle;
  assign ready_o = slow_i ? toggle : 1'b1;
  // One-cycle acknowledge per request, prompt or after a wait
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wait_cnt <= 2'h0;
      toggle <= 1'b0;
    end else begin
      toggle <= ~toggle;
      if (ack_o) begin
        ack_o <= 1'b0;
        wait_cnt <= 2'h0;
      end else if (req_i) begin
        if (!slow_i || wait_cnt == 2'h3) ack_o <= 1'b1;
        else wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule // serial_side_model

// File: testbench/peripheral_dma_channel_regs_test.sv
/*
  Self-checking bench of the channel pair register block.
  Assumes one 10 MHz clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module peripheral_dma_channel_regs_test;
  import periph_dma_regs_pkg::*;
  logic MCLK_I, RESET_I, half, slow;
  reg_req_s bus;
  logic [31:0] rdata, seed, v, d;
  xfer_size_e rx_size, tx_size;
  logic rx_ready, tx_ready, rx_ack, tx_ack, rx_req, tx_req;
  logic [31:0] rx_addr, tx_addr;
  logic rx_end, rx_full, tx_end, tx_empty, rx_on, tx_on;
  int failures, n_compared;
  // [31] half duplex, [25:16] status expected, [9:0] control write
  localparam logic [31:0] CTAB [12] = '{32'h0101_0101, 32'h0100_0002,
    32'h0100_0003, 32'h0000_0200, 32'h0001_0301, 32'h0001_0000,
    32'h8100_0100, 32'h8001_0001, 32'h8100_0100, 32'h8000_0002,
    32'h8001_0001, 32'h8000_0200};

  peripheral_dma_channel_regs u_dut (.MCLK_I(MCLK_I), .RESET_I(RESET_I),
    .BUS_I(bus), .RDATA_O(rdata), .HALF_DUPLEX_I(half),
    .RX_SIZE_I(rx_size), .TX_SIZE_I(tx_size), .RX_READY_I(rx_ready),
    .TX_READY_I(tx_ready), .RX_ACK_I(rx_ack), .TX_ACK_I(tx_ack),
    .RX_REQ_O(rx_req), .RX_ADDR_O(rx_addr), .TX_REQ_O(tx_req),
    .TX_ADDR_O(tx_addr), .RX_END_O(rx_end), .RX_FULL_O(rx_full),
    .TX_END_O(tx_end), .TX_EMPTY_O(tx_empty), .RX_ON_O(rx_on),
    .TX_ON_O(tx_on));
  serial_side_model u_rx_side (.clk_i(MCLK_I), .rst_i(RESET_I),
    .slow_i(slow), .req_i(rx_req), .ready_o(rx_ready), .ack_o(rx_ack));
  serial_side_model u_tx_side (.clk_i(MCLK_I), .rst_i(RESET_I),
    .slow_i(slow), .req_i(tx_req), .ready_o(tx_ready), .ack_o(tx_ack));

  // ------------------------------------------------------------
  // Bus master, checks and stimulus source
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] w);
    @(posedge MCLK_I);
    bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge MCLK_I);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    @(posedge MCLK_I);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge MCLK_I);
    bus.rd <= 1'b0;
    #1 r = rdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic xfer(input logic ch, input xfer_size_e sz);
    logic [11:0] b;
    logic [31:0] a1, a2, st;
    int n;
    b = ch ? 12'h108 : 12'h100;
    a1 = rnd();
    a2 = rnd();
    st = sz == SIZE_BYTE ? 32'h1 : sz == SIZE_HALF ? 32'h2 : 32'h4;
    if (ch) tx_size <= sz;
    else rx_size <= sz;
    wr(b, a1);
    wr(b + 12'h4, 32'h2);
    wr(b + 12'h10, a2);
    wr(b + 12'h14, 32'h1);
    wr(12'h120, ch ? 32'h100 : 32'h1);
    n = 0;
    while (!(ch ? tx_empty === 1'b1 : rx_full === 1'b1) && n < 300) begin
      @(posedge MCLK_I);
      n++;
    end
    if (n >= 300) begin
      failures++;
      conclude();
    end
    #1 chk("addr", a2 + st, ch ? tx_addr : rx_addr);
    chk("end", 32'h1, {31'h0, ch ? tx_end : rx_end});
    for (int i = 0; i < 3; i++) begin
      rd(b + (i == 0 ? 12'h4 : i == 1 ? 12'h10 : 12'h14), d);
      chk("zeroed", 32'h0, d);
    end
    wr(12'h120, 32'h202);
    wr(b + 12'h14, 32'h5);
    #1 chk("flags", 32'h0, {30'h0, ch ? {tx_end, tx_empty} :
      {rx_end, rx_full}});
    chk("idle req", 32'h0, {31'h0, ch ? tx_req : rx_req});
    wr(b + 12'h14, 32'h0);
  endtask

  initial begin
    MCLK_I = 1'b0;
    forever #50 MCLK_I = ~MCLK_I;
  end
  initial begin
    seed = 32'hE47F;
    bus = '0;
    {RESET_I, half, slow, rx_size, tx_size} = {3'b100, SIZE_BYTE, SIZE_BYTE};
    failures = 0;
    n_compared = 0;
    repeat (5) @(posedge MCLK_I);
    RESET_I <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      rd(12'h100 + 12'(i * 4), d);
      chk("reset value", 32'h0, d);
    end
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      wr(12'h100 + 12'(i * 4), v);
      rd(12'h100 + 12'(i * 4), d);
      chk("readback", i[0] ? {16'h0, v[15:0]} : v, d);
    end
    wr(12'h128, rnd());
    rd(12'h128, d);
    chk("unmapped", 32'h0, d);
    wr(12'h124, 32'hFFFF_FFFF);
    rd(12'h124, d);
    chk("status write", 32'h0, d);
    foreach (CTAB[i]) begin
      half <= CTAB[i][31];
      wr(12'h120, {22'h0, CTAB[i][9:0]});
      rd(12'h124, d);
      chk("status", {22'h0, CTAB[i][25:16]}, d);
      chk("enables", {22'h0, CTAB[i][25:16]},
        {23'h0, tx_on, 7'h0, rx_on});
    end
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      wr(12'h108 + 12'(i * 4 + (i / 2) * 8), v);
      rd(12'h100 + 12'(i * 4 + (i / 2) * 8), d);
      chk("shared", i[0] ? {16'h0, v[15:0]} : v, d);
      if (i[0]) begin
        wr(12'h100 + 12'(i * 4 + (i / 2) * 8), 32'h0);
        rd(12'h108 + 12'(i * 4 + (i / 2) * 8), d);
        chk("alias write", 32'h0, d);
      end
    end
    half <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      slow <= i[0];
      xfer(i < 3, xfer_size_e'(i % 3));
    end
    conclude();
  end
endmodule // peripheral_dma_channel_regs_test
